// [src/pei_pkg.sv]
// package for the parallel absolute-encoder input block
// assumes one logic clock domain; shared by the top and the decoder
package pei_pkg;

    // encoder word widths
    localparam int unsigned PEI_MAX_W      = 12;           // widest encoder word
    localparam logic [3:0]  PEI_LEN_MIN    = 4'h1;         // narrowest setting
    localparam logic [3:0]  PEI_LEN_MAX    = 4'hC;         // twelve lines
    localparam logic [3:0]  PEI_LEN_TRIG   = 4'hB;         // cap with transfer trigger
    localparam logic [3:0]  PEI_LEN_ZERO   = 4'h0;         // illegal setting

    // value limits
    localparam logic [11:0] PEI_MAX_VALUE  = 12'hFFF;      // 4095
    localparam logic [11:0] PEI_BCD_MAX    = 12'h3E7;      // 999, three digits
    localparam logic [3:0]  PEI_DIGIT_MAX  = 4'h9;         // largest bcd digit
    localparam logic [11:0] PEI_BCD_HUND   = 12'h064;      // digit weight 100
    localparam logic [11:0] PEI_BCD_TEN    = 12'h00A;      // digit weight 10

    // reset and default values
    localparam logic [11:0] PEI_WORD_ZERO  = 12'h000;      // cleared word
    localparam logic [11:0] PEI_CTT0_DEF   = 12'h000;      // first unit preset default

    // word type
    typedef logic [PEI_MAX_W-1:0] pei_word_type;

    // input code types
    typedef enum logic [1:0] {
        PEI_CODE_BIN,
        PEI_CODE_GRAY,
        PEI_CODE_BCD
    } pei_code_type;

    // preset sequencer states
    typedef enum logic [0:0] {
        PEI_ST_TRACK,
        PEI_ST_LOAD
    } pei_state_type;

endpackage

// [src/pei_decode.sv]
// combinational decoder: masks the active lines and converts the code
// assumes width already clamped to 1..12 by the caller
`timescale 1ns/1ps
module pei_decode
(
    // clock for the checks only
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // sampled lines and settings
    input  wire pei_pkg::pei_word_type raw,
    input  wire pei_pkg::pei_code_type code,
    input  wire logic [3:0]            width,
    // decoded word
    output pei_pkg::pei_word_type      value
);

    pei_pkg::pei_word_type masked;     // lines above width forced low
    pei_pkg::pei_word_type gray_bin;   // gray converted to binary
    logic [3:0]            dig [3];    // clamped bcd digits
    pei_pkg::pei_word_type bcd_bin;    // bcd converted to binary

    // per-bit masking and gray chain; zeros above the msb keep the chain exact
    genvar i;
    generate
        for (i = 0; i < pei_pkg::PEI_MAX_W; i++)
        begin : g_bit
            assign masked[i] = raw[i] & (4'(i) < width); // RULE4
            if (i == pei_pkg::PEI_MAX_W - 1)
            begin : g_top
                assign gray_bin[i] = masked[i]; // RULE12
            end
            else
            begin : g_low
                assign gray_bin[i] = masked[i] ^ gray_bin[i+1]; // RULE12
            end
        end
        for (i = 0; i < 3; i++)
        begin : g_dig
            // a nibble above nine is not a digit; it is held at nine
            assign dig[i] = (masked[4*i+3 -: 4] > pei_pkg::PEI_DIGIT_MAX) ?
                            pei_pkg::PEI_DIGIT_MAX : masked[4*i+3 -: 4];
        end
    endgenerate

    // weighted sum of the three digits, never above 999
    assign bcd_bin = 12'(12'(dig[2]) * pei_pkg::PEI_BCD_HUND)
                   + 12'(12'(dig[1]) * pei_pkg::PEI_BCD_TEN)
                   + 12'(dig[0]);

    // code select
    always_comb
    begin
        case (code)
            pei_pkg::PEI_CODE_GRAY: value = gray_bin; // RULE2
            pei_pkg::PEI_CODE_BCD:  value = bcd_bin;  // RULE2
            default:                value = masked;   // RULE2
        endcase
    end

    // nothing above the configured width survives in binary or gray
    a_width_mask: assert property (@(posedge mclk) disable iff (rst) // RULE4
        (code != pei_pkg::PEI_CODE_BCD) |-> ((value >> width) == pei_pkg::PEI_WORD_ZERO))
        else $error("decoded word has bits above the configured width");

    // gray msb passes unchanged
    a_gray_msb: assert property (@(posedge mclk) disable iff (rst) // RULE12
        (code == pei_pkg::PEI_CODE_GRAY) |-> (value[width-4'h1] == raw[width-4'h1]))
        else $error("gray conversion altered the top bit");

    // bcd stays within three digits
    a_bcd_range: assert property (@(posedge mclk) disable iff (rst) // RULE3
        (code == pei_pkg::PEI_CODE_BCD) |-> (value <= pei_pkg::PEI_BCD_MAX))
        else $error("bcd result above 999");

endmodule

// [src/pei_top.sv]
// parallel absolute-encoder input: samples up to twelve lines, decodes
// them and hands the word to a linked counter as its preset value
// assumes encoder lines and trigger pins are asynchronous to mclk
//
// Operation
// RULE1: width configurable one to twelve lines
// RULE2: decode as binary, gray or bcd
// RULE3: delivered word stays within 0 to 4095
// RULE4: active bits follow width, ascending from line0
// RULE5: trigger with binary or bcd caps eleven
// RULE6: only preset written; count waits for preset
// RULE7: preset trigger always fed from a source
// RULE8: sixteen-bit mode updates first unit preset
// RULE9: thirty-two-bit mode keeps first preset zero
// RULE10: transfer trigger latches word to avoid tearing
// RULE11: encoder supplies transfer timing when used
// RULE12: gray to binary by cascaded xor
`timescale 1ns/1ps
module pei_top
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // encoder pins
    input  wire pei_pkg::pei_word_type enc_lines,
    input  wire logic                  xfer_trig,
    input  wire logic                  preset_src,
    // configuration
    input  wire pei_pkg::pei_code_type cfg_code,
    input  wire logic [3:0]            cfg_data_len,
    input  wire logic                  cfg_use_trig,
    input  wire logic                  cfg_cnt32,
    // counter side
    output pei_pkg::pei_word_type      ctt0_preset,
    output pei_pkg::pei_word_type      wide_preset,
    output logic                       preset_load,
    // status
    output logic [3:0]                 active_width,
    output logic                       width_capped
);

    // all state in one record
    typedef struct packed {
        pei_pkg::pei_word_type  s1;        // first sync stage, read by s2 only
        pei_pkg::pei_word_type  s2;        // second sync stage
        pei_pkg::pei_word_type  s3;        // third sync stage
        pei_pkg::pei_word_type  stable;    // lines accepted once s2 and s3 agree
        logic [2:0]             trig_sync; // trigger sync chain
        logic                   trig_st;   // accepted trigger level
        logic [2:0]             src_sync;  // preset source sync chain
        logic                   src_st;    // accepted preset source level
        pei_pkg::pei_state_type state;     // preset sequencer
        pei_pkg::pei_word_type  latched;   // word held for the next preset
        pei_pkg::pei_word_type  ctt0;      // first counter-timer preset
        pei_pkg::pei_word_type  wide;      // combined 32-bit preset, low word
        logic                   load;      // preset execute pulse
        logic [3:0]             width;     // width in force
        logic                   capped;    // width was cut to eleven
    } pei_regs_type;

    pei_regs_type          st_reg;     // registered state
    pei_regs_type          st_next;    // next state
    logic [3:0]            len_clamp;  // setting forced into 1..12
    logic                  need_cap;   // trigger with binary or bcd
    logic [3:0]            width_c;    // width used for decoding
    pei_pkg::pei_word_type dec_value;  // decoded word
    logic                  trig_rise;  // accepted trigger edge
    logic                  src_rise;   // accepted source edge
    logic                  fire;       // preset request this cycle

    // width rules: illegal settings fall back to the nearest legal value
    always_comb
    begin
        if (cfg_data_len == pei_pkg::PEI_LEN_ZERO)
        begin
            len_clamp = pei_pkg::PEI_LEN_MIN; // RULE1
        end
        else if (cfg_data_len > pei_pkg::PEI_LEN_MAX)
        begin
            len_clamp = pei_pkg::PEI_LEN_MAX; // RULE1
        end
        else
        begin
            len_clamp = cfg_data_len;
        end
        // a torn read on a trigger edge is worst on the top bit, so it goes
        need_cap = cfg_use_trig && (cfg_code != pei_pkg::PEI_CODE_GRAY)
                   && (len_clamp > pei_pkg::PEI_LEN_TRIG); // RULE5
        width_c  = need_cap ? pei_pkg::PEI_LEN_TRIG : len_clamp; // RULE5
    end

    // decoder works on the filtered lines
    pei_decode u_decode
    (
        .mclk  (mclk),
        .rst   (rst),
        .raw   (st_reg.stable),
        .code  (cfg_code),
        .width (width_c),
        .value (dec_value)
    );

    // edge detection on accepted levels only, never on the first stage
    assign trig_rise = st_next.trig_st & ~st_reg.trig_st;
    assign src_rise  = st_next.src_st & ~st_reg.src_st;
    // without a trigger the preset source has to drive the load
    assign fire      = cfg_use_trig ? trig_rise : src_rise; // RULE7 RULE11

    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        // three-stage synchronisers
        st_next.s1 = enc_lines;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.trig_sync = {st_reg.trig_sync[1:0], xfer_trig};
        st_next.src_sync  = {st_reg.src_sync[1:0], preset_src};
        // a change counts once the second and third stages agree
        if (st_reg.s2 == st_reg.s3)
        begin
            st_next.stable = st_reg.s3;
        end
        if (st_reg.trig_sync[1] == st_reg.trig_sync[2])
        begin
            st_next.trig_st = st_reg.trig_sync[2];
        end
        if (st_reg.src_sync[1] == st_reg.src_sync[2])
        begin
            st_next.src_st = st_reg.src_sync[2];
        end
        st_next.width  = width_c;
        st_next.capped = need_cap;
        // latch on the trigger; otherwise follow the lines freely
        if (fire || !cfg_use_trig)
        begin
            st_next.latched = dec_value; // RULE10
        end
        st_next.load = 1'b0;
        // preset sequencer
        case (st_reg.state)
            pei_pkg::PEI_ST_TRACK:
            begin
                if (fire)
                begin
                    st_next.state = pei_pkg::PEI_ST_LOAD;
                end
            end
            pei_pkg::PEI_ST_LOAD:
            begin
                // only the preset is written; the count takes it on load
                if (cfg_cnt32)
                begin
                    st_next.ctt0 = pei_pkg::PEI_CTT0_DEF; // RULE9
                    st_next.wide = st_reg.latched;        // RULE9
                end
                else
                begin
                    st_next.ctt0 = st_reg.latched;        // RULE8
                end
                st_next.load  = 1'b1;                     // RULE6 RULE7
                st_next.state = pei_pkg::PEI_ST_TRACK;
            end
            default:
            begin
                st_next.state = pei_pkg::PEI_ST_TRACK;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_reg         <= '0;
            st_reg.state   <= pei_pkg::PEI_ST_TRACK;
            st_reg.ctt0    <= pei_pkg::PEI_CTT0_DEF;
            st_reg.width   <= pei_pkg::PEI_LEN_MIN;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign ctt0_preset  = st_reg.ctt0;
    assign wide_preset  = st_reg.wide;
    assign preset_load  = st_reg.load;
    assign active_width = st_reg.width;
    assign width_capped = st_reg.capped;

    // cap flag follows the trigger and code settings
    a_width_cap: assert property (@(posedge mclk) disable iff (rst) // RULE5
        (cfg_use_trig && cfg_code != pei_pkg::PEI_CODE_GRAY && cfg_data_len > 4'hB
         && cfg_data_len <= 4'hC) |=> (width_capped && active_width == 4'hB))
        else $error("width not capped to eleven with transfer trigger");

    // width always within one to twelve
    a_width_range: assert property (@(posedge mclk) disable iff (rst) // RULE1
        ##1 (active_width >= 4'h1 && active_width <= 4'hC))
        else $error("active width outside one to twelve");

    // a request yields a load two cycles later
    a_fire_load: assert property (@(posedge mclk) disable iff (rst) // RULE7
        (fire && st_reg.state == pei_pkg::PEI_ST_TRACK) |=> ##1 preset_load)
        else $error("preset request did not produce a load pulse");

    // load is a single-cycle pulse
    a_load_pulse: assert property (@(posedge mclk) disable iff (rst) // RULE6
        preset_load |=> !preset_load)
        else $error("load pulse longer than one cycle");

    // preset values change only together with a load
    a_preset_hold: assert property (@(posedge mclk) disable iff (rst) // RULE6
        ($changed(ctt0_preset) || $changed(wide_preset)) |-> preset_load)
        else $error("preset changed without a load");

    // sixteen-bit mode carries the latched word into the first unit
    a_ctt0_value: assert property (@(posedge mclk) disable iff (rst) // RULE8
        (st_reg.state == pei_pkg::PEI_ST_LOAD && !cfg_cnt32)
        |=> (preset_load && ctt0_preset == $past(st_reg.latched)))
        else $error("first unit preset missed the encoder word");

    // thirty-two-bit mode keeps the first unit at zero
    a_ctt0_zero: assert property (@(posedge mclk) disable iff (rst) // RULE9
        (st_reg.state == pei_pkg::PEI_ST_LOAD && cfg_cnt32)
        |=> (ctt0_preset == 12'h000 && wide_preset == $past(st_reg.latched)))
        else $error("first unit preset not held at zero");

    // trigger mode freezes the word between edges
    a_trig_latch: assert property (@(posedge mclk) disable iff (rst) // RULE10
        (cfg_use_trig && !fire) |=> $stable(st_reg.latched))
        else $error("latched word moved without a transfer trigger");

    // filtered lines move only when two stages agreed
    a_sync_agree: assert property (@(posedge mclk) disable iff (rst) // RULE4
        $changed(st_reg.stable) |-> $past(st_reg.s2 == st_reg.s3))
        else $error("lines accepted before the sync stages agreed");

endmodule

// [test/pei_enc_model.sv]
// behavioural absolute encoder with parallel outputs
// assumes the bench pulses go for one cycle and leaves 34 cycles per transfer
`timescale 1ns/1ps
module pei_enc_model
(
    // clock
    input  wire logic                  mclk,
    // position request
    input  wire logic                  go,
    input  wire logic                  slow,
    input  wire pei_pkg::pei_code_type code,
    input  wire logic [11:0]           pos,
    // encoder pins
    output pei_pkg::pei_word_type      enc_lines,
    output logic                       xfer_trig
);
    logic [4:0] cnt_reg;  // step within one transfer, 0 when idle
    logic [4:0] rise_at;  // strobe delay, prompt or slow
    // put a position on the lines in the encoder's own code
    function automatic pei_pkg::pei_word_type encode(input logic [11:0] p,
        input pei_pkg::pei_code_type c);
        logic [11:0] q;
        q = p % 12'h3E8;
        if (c == pei_pkg::PEI_CODE_GRAY)
            return p ^ (p >> 1);
        if (c == pei_pkg::PEI_CODE_BCD)
            return {4'(q / 12'h064), 4'((q / 12'h00A) % 12'h00A), 4'(q % 12'h00A)};
        return p;
    endfunction
    assign rise_at = slow ? 5'h0C : 5'h06;
    // idle state at time zero
    initial
    begin
        enc_lines = 12'h000;
        xfer_trig = 1'b0;
        cnt_reg   = 5'h00;
    end
    // lines settle first; the strobe comes only once they are steady
    always @(posedge mclk)
    begin
        if (go && cnt_reg == 5'h00)
        begin
            enc_lines <= encode(pos, code);
            cnt_reg   <= 5'h01;
        end
        else if (cnt_reg != 5'h00)
            cnt_reg <= (cnt_reg == 5'h1C) ? 5'h00 : cnt_reg + 5'h01;
        xfer_trig <= (cnt_reg >= rise_at) && (cnt_reg < rise_at + 5'h08);
    end
endmodule

// [test/testbench.sv]
// self-checking bench for the parallel encoder input block
// assumes pei_top and the encoder model; presets checked on the load pulse
`timescale 1ns/1ps
module testbench;
    // design hookup
    logic                  mclk, rst, preset_src, preset_load;
    logic                  cfg_use_trig, cfg_cnt32, width_capped, xfer_trig;
    logic [3:0]            cfg_data_len, active_width, len, ew, g_aw;
    pei_pkg::pei_code_type cfg_code, m_code, c;
    pei_pkg::pei_word_type enc_lines, ctt0_preset, wide_preset;
    // model control and bench state
    logic                  m_go, m_slow, c32, g_cap;
    logic [11:0]           m_pos, p, w, g_ctt, g_wide, exp_ctt, exp_wide;
    int                    failures, num_checks, loads, cycles, i;
    // 50 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    pei_top u_dut (.mclk(mclk), .rst(rst), .enc_lines(enc_lines), .xfer_trig(xfer_trig),
        .preset_src(preset_src), .cfg_code(cfg_code), .cfg_data_len(cfg_data_len),
        .cfg_use_trig(cfg_use_trig), .cfg_cnt32(cfg_cnt32), .ctt0_preset(ctt0_preset),
        .wide_preset(wide_preset), .preset_load(preset_load),
        .active_width(active_width), .width_capped(width_capped));
    pei_enc_model u_enc (.mclk(mclk), .go(m_go), .slow(m_slow), .code(m_code), .pos(m_pos),
        .enc_lines(enc_lines), .xfer_trig(xfer_trig));
    // width in force, with the cap that the transfer strobe brings
    function automatic logic [3:0] eff_w(input logic [3:0] n0,
        input pei_pkg::pei_code_type k, input logic trig);
        logic [3:0] n;
        n = (n0 == 4'h0) ? 4'h1 : ((n0 > 4'hC) ? 4'hC : n0);
        if (trig && k != pei_pkg::PEI_CODE_GRAY && n == 4'hC)
            n = 4'hB;
        return n;
    endfunction
    // word the counter should receive for given lines
    function automatic logic [11:0] exp_word(input logic [11:0] raw,
        input pei_pkg::pei_code_type k, input logic [3:0] n);
        logic [11:0] b;
        logic [3:0]  d [3];
        b = raw & ~(12'hFFF << n);
        if (k == pei_pkg::PEI_CODE_GRAY)
            for (int j = 10; j >= 0; j--) b[j] = b[j] ^ b[j+1];
        else if (k == pei_pkg::PEI_CODE_BCD)
        begin
            for (int j = 0; j < 3; j++) d[j] = (b[4*j +: 4] > 4'h9) ? 4'h9 : b[4*j +: 4];
            b = d[2] * 12'h064 + d[1] * 12'h00A + d[0];
        end
        return b;
    endfunction
    // one comparison
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // verdict and end of run
    task tally_and_finish;
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watch a span of cycles, count load pulses and keep what the last one delivered
    task automatic watch(input int lim);
        loads = 0;
        repeat (lim)
        begin
            @(posedge mclk);
            #1;
            if (preset_load === 1'b1)
            begin
                loads++;
                g_ctt  = ctt0_preset;
                g_wide = wide_preset;
                g_aw   = active_width;
                g_cap  = width_capped;
            end
        end
    endtask
    // one encoder transfer, strobe prompt or slow at random
    task automatic xfer(input logic [11:0] pv);
        @(posedge mclk);
        m_pos  <= pv;
        m_go   <= 1'b1;
        m_slow <= 1'($urandom % 2);
        @(posedge mclk);
        m_go <= 1'b0;
        watch(34);
    endtask
    // hang guard, well above the expected 1400 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(30492));
        {rst, preset_src, cfg_use_trig, cfg_cnt32, m_go, m_slow} = 6'h21;
        cfg_code = pei_pkg::PEI_CODE_BIN;
        m_code = pei_pkg::PEI_CODE_BIN;
        {cfg_data_len, m_pos, exp_ctt, exp_wide} = '0;
        {failures, num_checks, cycles} = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("reset preset", 12'h000, ctt0_preset);
        chk("reset load", 12'h000, {11'h000, preset_load});
        // strobed transfers over all codes; first six are full-width corners
        for (i = 0; i < 36; i++)
        begin
            c = pei_pkg::pei_code_type'(i % 3);
            len = (i < 6) ? 4'hC : 4'($urandom % 16);
            c32 = (i >= 6) && ($urandom % 2 == 1);
            p = (i < 6) ? 12'hFFF : 12'($urandom);
            @(posedge mclk);
            {cfg_code, cfg_data_len, cfg_cnt32, cfg_use_trig} <= {c, len, c32, 1'b1};
            m_code <= (i == 5) ? pei_pkg::PEI_CODE_BIN : c;
            xfer(p);
            ew = eff_w(len, c, 1'b1);
            w = exp_word(enc_lines, c, ew);
            exp_ctt = c32 ? 12'h000 : w;
            exp_wide = c32 ? w : exp_wide;
            chk("load count", 12'h001, 12'(loads));
            chk("ctt0 preset", exp_ctt, g_ctt);
            chk("wide preset", exp_wide, g_wide);
            chk("width", {8'h00, ew}, {8'h00, g_aw});
            chk("capped", 12'(ew != eff_w(len, c, 1'b0)), {11'h000, g_cap});
        end
        // free mode: strobe ignored, count waits for the preset source
        @(posedge mclk);
        {cfg_code, cfg_data_len, cfg_cnt32, cfg_use_trig} <= {pei_pkg::PEI_CODE_BIN, 4'hC, 2'b00};
        m_code <= pei_pkg::PEI_CODE_BIN;
        xfer(12'hA5C);
        chk("no load", 12'h000, 12'(loads));
        chk("preset held", exp_ctt, ctt0_preset);
        @(posedge mclk);
        preset_src <= 1'b1;
        watch(10);
        chk("source load", 12'h001, 12'(loads));
        chk("free word", 12'hA5C, g_ctt);
        chk("free width", 12'h00C, {8'h00, g_aw});
        @(posedge mclk);
        preset_src <= 1'b0;
        watch(6);
        tally_and_finish();
    end
endmodule
